// ---- hdl/mode_code_pkg.sv ----
// shared constants and carrier types for the flag and reset mode-code handler
// assumes a word-addressed host port and a 1553 front end that delivers decoded command words
package mode_code_pkg;

  // ==========================================================================
  // mode codes handled here
  // ==========================================================================
  localparam logic [4:0] MC_INHIBIT_FLAG = 5'h06; // inhibit_flag_command
  localparam logic [4:0] MC_OVERRIDE_INHIBIT = 5'h07; // override_inhibit_command
  localparam logic [4:0] MC_RESET_TERMINAL = 5'h08; // reset_terminal_command

  // ==========================================================================
  // host register map (word addresses)
  // ==========================================================================
  localparam int ADDR_W = 8; // host address width
  localparam int DATA_W = 16; // host data width
  localparam logic [ADDR_W-1:0] REG_RT_STATUS_BITS = 8'h06; // rt_status_bits, read/write
  localparam logic [ADDR_W-1:0] REG_BUILT_IN_TEST_WORD = 8'h13; // built_in_test_word, read only

  // field positions
  localparam int ST_TERMINAL_FLAG_POS = 0; // terminal_flag request from the host
  localparam int ST_BUSY_POS = 1; // busy request from the host
  localparam int BIT_SHUTDOWN_POS = 0; // two transmitter shutdown bits
  localparam int BIT_INHIBIT_POS = 4; // terminal-flag inhibit bit

  // reset values
  localparam logic [DATA_W-1:0] STATUS_BITS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BIT_WORD_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

  // ==========================================================================
  // carriers
  // ==========================================================================
  // one decoded mode command, offered for one cycle
  typedef struct packed {
    logic word_valid; // command word passed all validity checks
    logic broadcast; // addressed to the broadcast address
    logic tr; // transmit/receive bit
    logic [4:0] mode_code; // mode code field
    logic bus_id; // bus the command arrived on
    logic data_follows; // a contiguous data word followed the command
  } cmd_t;

  // status word bits this block owns
  typedef struct packed {
    logic message_error_flag;
    logic busy;
    logic broadcast_received_flag;
    logic terminal_flag;
  } status_t;

  // descriptor control word update
  typedef struct packed {
    logic descriptor_access_error;
    logic broadcast_indicator;
    logic buffer_select_toggle;
  } desc_t;

  // message info word
  typedef struct packed {
    logic bus_identifier;
    logic message_error_info;
    logic illegal_command_info;
    logic remote_to_remote_info;
    logic word_count_error_info;
  } info_t;

  // interrupt events, one bit each
  typedef struct packed {
    logic message_error_interrupt;
    logic illegal_command_interrupt;
    logic broadcast_received_interrupt;
    logic word_received_interrupt;
  } irq_t;

  // response class of a command
  typedef enum logic [2:0] {
    RESP_NONE = 3'b000,
    RESP_NORMAL = 3'b001,
    RESP_IN_FORM = 3'b010,
    RESP_ILLEGAL = 3'b011,
    RESP_DATA_ERR = 3'b100
  } resp_t;

  // response engine states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT_STATUS = 1'b1
  } state_t;

endpackage : mode_code_pkg

// ---- hdl/mode_cmd_classify.sv ----
// sorts one decoded mode command into its response class
// assumes the command fields are stable while it is read; purely combinational
module mode_cmd_classify (
  input wire mode_code_pkg::cmd_t cmd,
  input wire logic undefined_modecode_select,
  input wire logic illegal_table_bit,
  output mode_code_pkg::resp_t kind
);

  // ==========================================================================
  // classification
  // ==========================================================================
  logic ours; // one of the three mode codes served here

  always_comb begin
    ours = (cmd.mode_code == mode_code_pkg::MC_INHIBIT_FLAG) ||
           (cmd.mode_code == mode_code_pkg::MC_OVERRIDE_INHIBIT) ||
           (cmd.mode_code == mode_code_pkg::MC_RESET_TERMINAL);
    kind = mode_code_pkg::RESP_NONE;
    if (!ours || !cmd.word_valid) begin
      // other codes belong elsewhere; bad words are dropped
      kind = mode_code_pkg::RESP_NONE;
    end else if (!cmd.tr && undefined_modecode_select) begin
      // undefined code told to be ignored
      kind = mode_code_pkg::RESP_NONE;
    end else if (cmd.data_follows) begin
      // a stray data word outranks the illegal, in-form and normal answers
      kind = mode_code_pkg::RESP_DATA_ERR;
    end else if (!cmd.tr) begin
      kind = illegal_table_bit ? mode_code_pkg::RESP_ILLEGAL : mode_code_pkg::RESP_IN_FORM;
    end else begin
      kind = mode_code_pkg::RESP_NORMAL;
    end
  end

endmodule : mode_cmd_classify

// ---- hdl/rt_flag_reset_handler.sv ----
// response engine for the inhibit, override-inhibit and reset-terminal mode commands
// assumes a front end that offers decoded commands and reports when the status word left
module rt_flag_reset_handler (
  input wire logic clk,
  input wire logic rst,
  input wire logic master_reset_input,
  input wire logic soft_reset_bit,
  input wire logic cmd_valid,
  input wire mode_code_pkg::cmd_t cmd,
  input wire logic undefined_modecode_select,
  input wire logic illegal_table_bit,
  input wire logic status_done,
  input wire logic [1:0] tx_shutdown_set,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [mode_code_pkg::ADDR_W-1:0] host_addr,
  input wire logic [mode_code_pkg::DATA_W-1:0] host_wdata,
  input wire mode_code_pkg::irq_t irq_enable,
  output logic [mode_code_pkg::DATA_W-1:0] host_rdata,
  output logic status_req,
  output mode_code_pkg::status_t status_word,
  output logic desc_wr,
  output mode_code_pkg::desc_t desc,
  output logic info_wr,
  output mode_code_pkg::info_t info,
  output mode_code_pkg::irq_t irq
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic any_rst; // hardware, master or software reset
  mode_code_pkg::resp_t kind; // class of the offered command
  logic take; // command accepted this cycle
  logic send; // status word goes out for it
  mode_code_pkg::state_t state_q, state_d;
  logic me_q, me_d; // message error status bit
  logic bcr_q, bcr_d; // broadcast received status bit
  logic inhibit_q, inhibit_d; // terminal-flag inhibit
  logic [1:0] shutdown_q, shutdown_d; // transmitter shutdown bits
  logic buf_sel_q, buf_sel_d; // current data buffer
  logic pend_q, pend_d; // reset terminal waits for its status
  logic [mode_code_pkg::DATA_W-1:0] host_status_q, host_status_d; // rt_status_bits
  logic status_req_q, status_req_d;
  mode_code_pkg::status_t status_word_q, status_word_d;
  logic desc_wr_q, desc_wr_d;
  mode_code_pkg::desc_t desc_q, desc_d;
  logic info_wr_q, info_wr_d;
  mode_code_pkg::info_t info_q, info_d;
  mode_code_pkg::irq_t irq_q, irq_d, offered;
  logic [mode_code_pkg::DATA_W-1:0] bit_word; // built_in_test_word view
  logic [mode_code_pkg::DATA_W-1:0] rdata_q, rdata_d;

  assign any_rst = rst || master_reset_input || soft_reset_bit;

  mode_cmd_classify u_classify (
    .cmd(cmd),
    .undefined_modecode_select(undefined_modecode_select),
    .illegal_table_bit(illegal_table_bit),
    .kind(kind)
  );

  // commands arriving while a status word is pending are dropped
  assign take = cmd_valid && (state_q == mode_code_pkg::ST_IDLE) && (kind != mode_code_pkg::RESP_NONE);

  // ==========================================================================
  // response engine: next values
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    me_d = me_q;
    bcr_d = bcr_q;
    inhibit_d = inhibit_q;
    shutdown_d = shutdown_q;
    buf_sel_d = buf_sel_q;
    pend_d = pend_q;
    host_status_d = host_status_q;
    status_req_d = 1'b0;
    status_word_d = status_word_q;
    desc_wr_d = 1'b0;
    desc_d = desc_q;
    info_wr_d = 1'b0;
    info_d = info_q;
    irq_d = '0;
    offered = '0;
    send = 1'b0;
    if (take) begin
      desc_wr_d = 1'b1;
      info_wr_d = 1'b1;
      buf_sel_d = ~buf_sel_q;
      desc_d.buffer_select_toggle = ~buf_sel_q;
      desc_d.broadcast_indicator = cmd.broadcast;
      desc_d.descriptor_access_error = 1'b1;
      info_d = '0;
      info_d.bus_identifier = cmd.bus_id;
      offered.word_received_interrupt = 1'b1;
      offered.broadcast_received_interrupt = cmd.broadcast;
      send = !cmd.broadcast;
      if (cmd.broadcast) begin
        bcr_d = 1'b1;
      end
      case (kind)
        mode_code_pkg::RESP_NORMAL: begin
          me_d = 1'b0;
          desc_d.descriptor_access_error = 1'b0;
          if (cmd.mode_code == mode_code_pkg::MC_OVERRIDE_INHIBIT) begin
            inhibit_d = 1'b0;
          end else if (cmd.mode_code == mode_code_pkg::MC_INHIBIT_FLAG) begin
            inhibit_d = 1'b1;
          end else begin
            // reset terminal, finished once status is out
            pend_d = send;
          end
        end
        mode_code_pkg::RESP_IN_FORM: begin
          me_d = 1'b0;
        end
        mode_code_pkg::RESP_ILLEGAL: begin
          me_d = 1'b1;
          info_d.illegal_command_info = 1'b1;
          info_d.message_error_info = 1'b1;
          offered.illegal_command_interrupt = 1'b1;
        end
        mode_code_pkg::RESP_DATA_ERR: begin
          me_d = 1'b1;
          send = 1'b0;
          bcr_d = bcr_q;
          desc_d.broadcast_indicator = 1'b0;
          info_d.message_error_info = 1'b1;
          info_d.word_count_error_info = 1'b1;
          offered.broadcast_received_interrupt = 1'b0;
          offered.message_error_interrupt = 1'b1;
        end
        default: begin
          me_d = me_q;
        end
      endcase
      // broadcast reset has no status, so it completes now
      if (kind == mode_code_pkg::RESP_NORMAL && cmd.mode_code == mode_code_pkg::MC_RESET_TERMINAL && !send) begin
        me_d = 1'b0;
        bcr_d = 1'b0;
        inhibit_d = 1'b0;
        shutdown_d = '0;
        host_status_d[mode_code_pkg::ST_BUSY_POS] = 1'b0;
      end
      irq_d = offered & irq_enable;
      if (send) begin
        status_req_d = 1'b1;
        state_d = mode_code_pkg::ST_WAIT_STATUS;
      end
    end else if (state_q == mode_code_pkg::ST_WAIT_STATUS && status_done) begin
      state_d = mode_code_pkg::ST_IDLE;
      if (pend_q) begin
        pend_d = 1'b0;
        me_d = 1'b0;
        bcr_d = 1'b0;
        inhibit_d = 1'b0;
        shutdown_d = '0;
        host_status_d[mode_code_pkg::ST_BUSY_POS] = 1'b0;
      end
    end
    status_word_d.message_error_flag = me_d;
    status_word_d.broadcast_received_flag = bcr_d;
    status_word_d.busy = host_status_q[mode_code_pkg::ST_BUSY_POS];
    status_word_d.terminal_flag = host_status_q[mode_code_pkg::ST_TERMINAL_FLAG_POS] && !inhibit_d;
    if (!send) begin
      status_word_d = status_word_q;
    end
    // a new shutdown beats a clear in the same cycle
    shutdown_d = shutdown_d | tx_shutdown_set;
    // host write beats the hardware busy clear
    if (host_wr && host_addr == mode_code_pkg::REG_RT_STATUS_BITS) begin
      host_status_d = host_wdata;
    end
  end

  // ==========================================================================
  // response engine: registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (any_rst) begin
      state_q <= mode_code_pkg::ST_IDLE;
      me_q <= 1'b0;
      bcr_q <= 1'b0;
      inhibit_q <= 1'b0;
      shutdown_q <= '0;
      buf_sel_q <= 1'b0;
      pend_q <= 1'b0;
      host_status_q <= mode_code_pkg::STATUS_BITS_RESET;
      status_req_q <= 1'b0;
      status_word_q <= '0;
      desc_wr_q <= 1'b0;
      desc_q <= '0;
      info_wr_q <= 1'b0;
      info_q <= '0;
      irq_q <= '0;
    end else begin
      state_q <= state_d;
      me_q <= me_d;
      bcr_q <= bcr_d;
      inhibit_q <= inhibit_d;
      shutdown_q <= shutdown_d;
      buf_sel_q <= buf_sel_d;
      pend_q <= pend_d;
      host_status_q <= host_status_d;
      status_req_q <= status_req_d;
      status_word_q <= status_word_d;
      desc_wr_q <= desc_wr_d;
      desc_q <= desc_d;
      info_wr_q <= info_wr_d;
      info_q <= info_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================================
  // host read port
  // ==========================================================================
  // test word built from live bits; other positions read zero
  always_comb begin
    bit_word = mode_code_pkg::BIT_WORD_RESET;
    bit_word[mode_code_pkg::BIT_INHIBIT_POS] = inhibit_q;
    bit_word[mode_code_pkg::BIT_SHUTDOWN_POS +: $bits(shutdown_q)] = shutdown_q;
    rdata_d = rdata_q;
    if (host_rd) begin
      case (host_addr)
        mode_code_pkg::REG_RT_STATUS_BITS: rdata_d = host_status_q;
        mode_code_pkg::REG_BUILT_IN_TEST_WORD: rdata_d = bit_word;
        default: rdata_d = mode_code_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= mode_code_pkg::UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign host_rdata = rdata_q;
  assign status_req = status_req_q;
  assign status_word = status_word_q;
  assign desc_wr = desc_wr_q;
  assign desc = desc_q;
  assign info_wr = info_wr_q;
  assign info = info_q;
  assign irq = irq_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (any_rst);

  sequence s_take_normal(logic [4:0] code);
    take && kind == mode_code_pkg::RESP_NORMAL && cmd.mode_code == code;
  endsequence

  sequence s_reset_done;
    state_q == mode_code_pkg::ST_WAIT_STATUS && status_done && pend_q && tx_shutdown_set == 2'b00 && !host_wr;
  endsequence

  a_override_clears_inhibit: assert property (s_take_normal(mode_code_pkg::MC_OVERRIDE_INHIBIT) |=> !inhibit_q)
    else $error("override did not clear inhibit");
  a_inhibit_masks_flag: assert property (s_take_normal(mode_code_pkg::MC_INHIBIT_FLAG) ##1 status_req_q
    |-> inhibit_q && !status_word_q.terminal_flag) else $error("inhibited flag leaked");
  a_flag_passes_through: assert property (status_req_q && !inhibit_q
    |-> status_word_q.terminal_flag == $past(host_status_q[mode_code_pkg::ST_TERMINAL_FLAG_POS]))
    else $error("terminal flag not passed");
  a_ignored_is_quiet: assert property (cmd_valid && kind == mode_code_pkg::RESP_NONE
    && state_q == mode_code_pkg::ST_IDLE
    |=> !desc_wr_q && !info_wr_q && !status_req_q && irq_q == '0) else $error("ignored command had effect");
  a_broadcast_no_status: assert property (take && cmd.broadcast |=> !status_req_q && desc_wr_q)
    else $error("broadcast answered");
  a_data_word_error: assert property (take && kind == mode_code_pkg::RESP_DATA_ERR
    |=> me_q && !status_req_q && info_q.word_count_error_info && desc_q.descriptor_access_error
    && irq_q.word_received_interrupt == $past(irq_enable.word_received_interrupt))
    else $error("data word case wrong");
  a_illegal_info: assert property (take && kind == mode_code_pkg::RESP_ILLEGAL
    |=> me_q && info_q.illegal_command_info && info_q.message_error_info) else $error("illegal info wrong");
  a_reset_after_status: assert property (s_reset_done |=> !me_q && !bcr_q && !inhibit_q && shutdown_q == 2'b00
    && !host_status_q[mode_code_pkg::ST_BUSY_POS]) else $error("reset terminal incomplete");
  a_buffer_toggles: assert property (take |=> buf_sel_q != $past(buf_sel_q)
    && desc_q.buffer_select_toggle == buf_sel_q) else $error("buffer select not toggled");
  a_irq_gated: assert property ((irq_q & ~$past(irq_enable)) == '0) else $error("disabled interrupt raised");
  a_soft_reset_inhibit: assert property (@(posedge clk) disable iff (rst) soft_reset_bit |=> !inhibit_q)
    else $error("soft reset kept inhibit");

endmodule : rt_flag_reset_handler

// ---- verif/bus_ctrl_model.sv ----
// behavioural bus controller and status encoder facing the mode-code handler
// assumes one clock shared with the handler; commands are offered for exactly one cycle
module bus_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic status_req,
  input wire logic [7:0] dly,
  output logic cmd_valid,
  output mode_code_pkg::cmd_t cmd,
  output logic status_done
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] cnt; // cycles left until the status word has left

  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    status_done = 1'b0;
    cnt = 8'h00;
  end

  // ==========================================================================
  // command issue
  // ==========================================================================
  // whole command, one cycle
  task automatic send(mode_code_pkg::cmd_t c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // released fields show the inverse so a stale value can never pass
    cmd <= mode_code_pkg::cmd_t'(~c);
  endtask : send

  // ==========================================================================
  // status transmission, prompt (dly 1) or slow (larger dly)
  // ==========================================================================
  always @(posedge clk) begin
    status_done <= 1'b0;
    if (rst) begin
      cnt <= 8'h00;
    end else if (status_req) begin
      cnt <= dly;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      // done pulses once, as the last bit leaves
      if (cnt == 8'h01) begin
        status_done <= 1'b1;
      end
    end
  end

endmodule : bus_ctrl_model

// ---- verif/rt_flag_reset_handler_tb.sv ----
// self-checking bench for the flag and reset mode-code handler
// assumes the handler's in-file assertions and the bus controller model beside it
module rt_flag_reset_handler_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0, rst = 1'b1, master_reset_input = 1'b0, soft_reset_bit = 1'b0;
  logic undefined_modecode_select = 1'b0, illegal_table_bit = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
  logic [1:0] tx_shutdown_set = 2'h0;
  logic [7:0] host_addr = 8'h00, dly = 8'h01;
  logic [15:0] host_wdata = 16'h0000, host_rdata;
  mode_code_pkg::irq_t irq_enable = 4'hf, irq;
  mode_code_pkg::cmd_t cmd;
  mode_code_pkg::status_t status_word;
  mode_code_pkg::desc_t desc;
  mode_code_pkg::info_t info;
  logic cmd_valid, status_done, status_req, desc_wr, info_wr;
  logic bsel = 1'b0; // expected buffer select, toggles on each descriptor update
  int mismatches = 0, n_tests = 0;

  always #5 clk = ~clk;

  rt_flag_reset_handler u_dut (.clk(clk), .rst(rst), .master_reset_input(master_reset_input),
    .soft_reset_bit(soft_reset_bit), .cmd_valid(cmd_valid), .cmd(cmd),
    .undefined_modecode_select(undefined_modecode_select), .illegal_table_bit(illegal_table_bit),
    .status_done(status_done), .tx_shutdown_set(tx_shutdown_set), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .irq_enable(irq_enable), .host_rdata(host_rdata),
    .status_req(status_req), .status_word(status_word), .desc_wr(desc_wr), .desc(desc),
    .info_wr(info_wr), .info(info), .irq(irq));

  bus_ctrl_model u_bc (.clk(clk), .rst(rst), .status_req(status_req), .dly(dly), .cmd_valid(cmd_valid),
    .cmd(cmd), .status_done(status_done));

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic complete_run();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    check("host_rdata", host_rdata, e);
  endtask : rd

  function automatic mode_code_pkg::cmd_t mk(logic v, logic b, logic t, logic [4:0] m, logic df);
    return mode_code_pkg::cmd_t'({v, b, t, m, 1'b1, df});
  endfunction : mk

  // one command, its one-cycle answer judged, then the status wait
  task automatic do_cmd(mode_code_pkg::cmd_t c, logic esr, logic [3:0] esw, logic [3:0] swm, logic ewr,
                        logic [1:0] ed, logic [4:0] ei, logic [3:0] eq);
    int k;
    u_bc.send(c);
    #1;
    if (ewr) begin
      bsel = ~bsel;
    end
    check("status_req", 16'(status_req), 16'(esr));
    check("status_word", 16'(status_word & swm), 16'(esw & swm));
    check("desc_wr", 16'(desc_wr), 16'(ewr));
    check("info_wr", 16'(info_wr), 16'(ewr));
    check("desc", 16'(desc), 16'({ed, bsel}));
    check("info", 16'(info), 16'(ei));
    check("irq", 16'(irq), 16'(eq));
    k = 0;
    while (esr && status_done !== 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 100) begin
      mismatches++;
      complete_run();
    end
    repeat (2) @(posedge clk);
  endtask : do_cmd

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_regs();
    rd(8'h06, 16'h0000);
    rd(8'h13, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(8'h13, 16'hffff);
    rd(8'h13, 16'h0000);
    wr(8'h06, 16'h0001);
    rd(8'h06, 16'h0001);
  endtask : t_regs

  // inhibit masks the host flag, override restores it, broadcast withholds status
  task automatic t_flag();
    do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h06, 1'b0), 1'b1, 4'h0, 4'hf, 1'b1, 2'h0, 5'h10, 4'h1);
    rd(8'h13, 16'h0010);
    do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h07, 1'b0), 1'b1, 4'h1, 4'hf, 1'b1, 2'h0, 5'h10, 4'h1);
    rd(8'h13, 16'h0000);
    // status word is only refreshed when it is sent, so a broadcast leaves it as it was
    do_cmd(mk(1'b1, 1'b1, 1'b1, 5'h07, 1'b0), 1'b0, 4'h1, 4'hf, 1'b1, 2'h1, 5'h10, 4'h3);
  endtask : t_flag

  // soft then master reset each lift the inhibit
  task automatic t_resets();
    for (int i = 0; i < 2; i++) begin
      // first pass still carries the broadcast-received bit left by the broadcast override
      do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h06, 1'b0), 1'b1, (i == 0) ? 4'h2 : 4'h0, 4'hf, 1'b1, 2'h0, 5'h10, 4'h1);
      @(posedge clk);
      soft_reset_bit <= (i == 0);
      master_reset_input <= (i == 1);
      @(posedge clk);
      soft_reset_bit <= 1'b0;
      master_reset_input <= 1'b0;
      bsel = 1'b0;
      rd(8'h13, 16'h0000);
      check("status_word", 16'(status_word), 16'h0000);
    end
  endtask : t_resets

  // reset-terminal clears shutdown, inhibit and flags after a slow status
  task automatic t_reset_term();
    @(posedge clk);
    tx_shutdown_set <= 2'h3;
    @(posedge clk);
    tx_shutdown_set <= 2'h0;
    do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h06, 1'b0), 1'b1, 4'h0, 4'h9, 1'b1, 2'h0, 5'h10, 4'h1);
    rd(8'h13, 16'h0013);
    // host raises busy so the reset-terminal clear has something to remove
    wr(8'h06, 16'h0002);
    dly <= 8'h05;
    do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h08, 1'b0), 1'b1, 4'h4, 4'hf, 1'b1, 2'h0, 5'h10, 4'h1);
    check("status_word", 16'(status_word), 16'h0004);
    rd(8'h13, 16'h0000);
    rd(8'h06, 16'h0000);
    do_cmd(mk(1'b1, 1'b1, 1'b1, 5'h08, 1'b0), 1'b0, 4'h0, 4'h8, 1'b1, 2'h1, 5'h10, 4'h3);
  endtask : t_reset_term

  // undefined codes in form and illegalized, plain and broadcast
  task automatic t_undef();
    illegal_table_bit <= 1'b0;
    do_cmd(mk(1'b1, 1'b0, 1'b0, 5'h07, 1'b0), 1'b1, 4'h0, 4'h8, 1'b1, 2'h2, 5'h10, 4'h1);
    illegal_table_bit <= 1'b1;
    do_cmd(mk(1'b1, 1'b0, 1'b0, 5'h06, 1'b0), 1'b1, 4'h8, 4'h8, 1'b1, 2'h2, 5'h1c, 4'h5);
    do_cmd(mk(1'b1, 1'b1, 1'b0, 5'h08, 1'b0), 1'b0, 4'h8, 4'ha, 1'b1, 2'h3, 5'h1c, 4'h7);
    illegal_table_bit <= 1'b0;
    do_cmd(mk(1'b1, 1'b1, 1'b0, 5'h06, 1'b0), 1'b0, 4'h8, 4'ha, 1'b1, 2'h3, 5'h10, 4'h3);
  endtask : t_undef

  // ignored commands leave every output as it stood
  task automatic t_ignored();
    undefined_modecode_select <= 1'b1;
    do_cmd(mk(1'b1, 1'b0, 1'b0, 5'h07, 1'b0), 1'b0, 4'h8, 4'hf, 1'b0, 2'h3, 5'h10, 4'h0);
    undefined_modecode_select <= 1'b0;
    do_cmd(mk(1'b0, 1'b0, 1'b1, 5'h07, 1'b0), 1'b0, 4'h8, 4'hf, 1'b0, 2'h3, 5'h10, 4'h0);
    do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h09, 1'b0), 1'b0, 4'h8, 4'hf, 1'b0, 2'h3, 5'h10, 4'h0);
  endtask : t_ignored

  // trailing data word, then masked interrupts with a slow encoder
  task automatic t_data_mask();
    do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h07, 1'b1), 1'b0, 4'h8, 4'h8, 1'b1, 2'h2, 5'h19, 4'h9);
    irq_enable <= 4'h0;
    dly <= 8'h14;
    do_cmd(mk(1'b1, 1'b0, 1'b1, 5'h07, 1'b0), 1'b1, 4'h2, 4'hf, 1'b1, 2'h0, 5'h10, 4'h0);
    irq_enable <= 4'hf;
  endtask : t_data_mask

  // ==========================================================================
  // main sequence and hang guard
  // ==========================================================================
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_flag();
    t_resets();
    t_reset_term();
    t_undef();
    t_ignored();
    t_data_mask();
    complete_run();
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    complete_run();
  end

endmodule : rt_flag_reset_handler_tb
